// file: hw/sdh_error_pointer_injector.sv
// sdh transmit stimulus: error/alarm insertion, pointer actions, clock select
//
// Function
// - insertion off: no error goes into any frame; the alarm still follows inject_alarm
// - manual: each trigger injects the set count once, then clean again
// - permanent: every frame injected, trigger only reflects status
// - alternate: repeat set count of errored frames then set count of clean
// - rate: inject continuously at one decade ratio from 1E-3 to 1E-10
// - rate 1E-3 corrupts exactly one frame in every thousand
// - signed frequency offset raises or lowers the line bit rate
// - active pointer stimulus feeds the chosen sequence into au or tu pointer
// - sequence none: pointers unmodified, no justifications
// - single alternating: positive and negative justifications alternate
// - regular plus double: positive stream with an added double positive
// - regular plus missing: negative stream with one justification missing
// - double alternating: two positives then two negatives, repeating
// - movement shifts pointer by amount, jump loads the value directly
// - direction positive increases pointer, negative decreases it
// - pointer change sends enabled new data flag if included, else disabled
// - overhead replace mode overwrites one chosen overhead region
// - transmit clock selects internal, external or recovered clock
// - through or overhead replace mode forces the recovered clock
// - external or recovered source reports whether that clock is present
`timescale 1ns/100ps
`default_nettype none
`include "sdh_inj_defines.svh"

module sdh_error_pointer_injector import sdh_inj_pkg::*; (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               frame_start,
   input  wire insert_mode_t       insert_mode,
   input  wire logic               inject_alarm,
   input  wire logic               insert_trigger,
   input  wire logic [15:0]        burst_count,
   input  wire logic [15:0]        alt_err_frames,
   input  wire logic [15:0]        alt_clean_frames,
   input  wire logic [3:0]         rate_exp,
   input  wire logic signed [15:0] freq_offset,
   input  wire logic               ptr_on_tu,
   input  wire ptr_seq_t           ptr_seq,
   input  wire logic [15:0]        just_period,
   input  wire logic               ptr_jump,
   input  wire logic               ptr_dir_neg,
   input  wire logic               ptr_flag_incl,
   input  wire logic [9:0]         ptr_amount,
   input  wire logic               ptr_apply,
   input  wire port_mode_t         port_mode,
   input  wire oh_region_t         oh_region,
   input  wire logic [6:0]         oh_byte_pos,
   input  wire clk_src_t           clk_select,
   input  wire logic               ext_clk_seen,
   input  wire logic               rec_clk_seen,
   output logic                    frame_inject_ff,
   output logic                    inject_alarm_ff,
   output logic                    burst_busy_ff,
   output logic                    insert_active_ff,
   output logic [31:0]             nco_step_ff,
   output logic                    ptr_tu_ff,
   output logic [9:0]              ptr_value_ff,
   output logic [3:0]              new_data_flag_ff,
   output logic                    just_pos_ff,
   output logic                    just_neg_ff,
   output logic                    oh_replace_ff,
   output oh_region_t              oh_region_ff,
   output logic [6:0]              oh_byte_ff,
   output clk_src_t                clk_src_ff,
   output logic                    clk_present_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // insertion state

   insert_mode_t mode_ff;
   inj_state_t   state_ff;
   inj_state_t   nxt_state;
   logic [15:0]  left_ff;
   logic [15:0]  nxt_left;
   logic         nxt_inject;
   logic         trig_pend_ff;
   logic         rate_hit;
   logic [33:0]  rate_limit;

   // a trigger outside manual mode is only status, never queued
   wire trig_ok      = insert_trigger && (insert_mode == INS_MANUAL);
   wire burst_start  = (state_ff != ST_BURST) && trig_pend_ff && (burst_count != 16'h0000);
   wire trig_consume = frame_start && (insert_mode == INS_MANUAL) && (state_ff != ST_BURST);
   wire nxt_trig     = trig_ok || (trig_pend_ff && !trig_consume);
   wire in_alt       = (state_ff == ST_ALT_ERR) || (state_ff == ST_ALT_CLEAN);
   wire cont_mode    = (insert_mode == INS_PERM) || (insert_mode == INS_ALT) ||
                       (insert_mode == INS_RATE);

   assign rate_limit = (rate_exp <= 4'h3) ? `RATE_E3 :
                       (rate_exp == 4'h4) ? `RATE_E4 :
                       (rate_exp == 4'h5) ? `RATE_E5 :
                       (rate_exp == 4'h6) ? `RATE_E6 :
                       (rate_exp == 4'h7) ? `RATE_E7 :
                       (rate_exp == 4'h8) ? `RATE_E8 :
                       (rate_exp == 4'h9) ? `RATE_E9 : `RATE_E10;

   // counter restarts whenever rate mode is left, so each entry starts clean
   frame_interval_counter #(.W(34)) rate_div (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clr     (insert_mode != INS_RATE),
      .tick    (frame_start),
      .limit   (rate_limit),
      .hit     (rate_hit)
   );

   // evaluated only at frame_start; between frames all but the trigger and busy flags hold
   always_comb begin
      logic        ph;
      logic [15:0] cur;
      ph         = 1'b1;
      cur        = 16'h0000;
      nxt_state  = ST_IDLE;
      nxt_left   = 16'h0000;
      nxt_inject = 1'b0;
      case (insert_mode)
         INS_OFF: begin
            nxt_inject = 1'b0;
         end
         INS_PERM: begin
            nxt_inject = 1'b1;
         end
         INS_RATE: begin
            nxt_inject = rate_hit;
         end
         INS_MANUAL: begin
            cur = burst_start ? burst_count : left_ff;
            if (state_ff == ST_BURST || burst_start) begin
               nxt_inject = 1'b1;
               nxt_left   = cur - 16'h0001;
               nxt_state  = (cur <= 16'h0001) ? ST_IDLE : ST_BURST;
            end
         end
         INS_ALT: begin
            ph  = in_alt ? (state_ff == ST_ALT_ERR) : 1'b1;
            cur = in_alt ? left_ff : alt_err_frames;
            if (cur == 16'h0000) begin
               ph  = ~ph;
               cur = ph ? alt_err_frames : alt_clean_frames;
            end
            nxt_inject = ph && (cur != 16'h0000);
            if (cur <= 16'h0001) begin
               nxt_state = ph ? ST_ALT_CLEAN : ST_ALT_ERR;
               nxt_left  = ph ? alt_clean_frames : alt_err_frames;
            end else begin
               nxt_state = ph ? ST_ALT_ERR : ST_ALT_CLEAN;
               nxt_left  = cur - 16'h0001;
            end
         end
         default: begin
            nxt_inject = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_ff          <= INS_OFF;
         state_ff         <= ST_IDLE;
         left_ff          <= 16'h0000;
         trig_pend_ff     <= 1'b0;
         frame_inject_ff  <= 1'b0;
         inject_alarm_ff  <= 1'b0;
         insert_active_ff <= 1'b0;
         burst_busy_ff    <= 1'b0;
      end else begin
         trig_pend_ff  <= nxt_trig;
         burst_busy_ff <= nxt_trig || burst_start || (state_ff == ST_BURST);
         if (frame_start) begin
            mode_ff          <= insert_mode;
            state_ff         <= nxt_state;
            left_ff          <= nxt_left;
            frame_inject_ff  <= nxt_inject;
            inject_alarm_ff  <= inject_alarm;
            insert_active_ff <= cont_mode;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line rate offset

   wire [31:0] offset_ext = {{16{freq_offset[15]}}, freq_offset};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         nco_step_ff <= `NCO_NOMINAL;
      end else begin
         nco_step_ff <= `NCO_NOMINAL + offset_ext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pointer stimulus

   // amount must stay below the span; larger values wrap only once
   function automatic logic [9:0] ptr_move(input logic [9:0]  ptr,
                                           input logic [9:0]  amt,
                                           input logic        neg,
                                           input logic [10:0] span);
      logic [10:0] sum;
      sum = neg ? ((ptr >= amt) ? {1'b0, ptr} - {1'b0, amt}
                                : {1'b0, ptr} + span - {1'b0, amt})
                : {1'b0, ptr} + {1'b0, amt};
      if (!neg && sum >= span) begin
         sum = sum - span;
      end
      return sum[9:0];
   endfunction

   logic       apply_pend_ff;
   logic       dbl_pend_ff;
   logic [2:0] phase_ff;
   logic       just_hit;
   logic       seq_pos;
   logic       seq_neg;

   wire [10:0] ptr_span   = ptr_on_tu ? `PTR_SPAN_TU : `PTR_SPAN_AU;
   wire        apply_now  = frame_start && apply_pend_ff;
   wire        nxt_apply  = ptr_apply || (apply_pend_ff && !frame_start);
   wire        special_ph = (phase_ff == `SEQ_SPECIAL_PH);
   wire        seq_frame  = frame_start && !apply_now;

   frame_interval_counter #(.W(16)) just_div (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clr     (ptr_seq == SEQ_NONE),
      .tick    (seq_frame),
      .limit   (just_period),
      .hit     (just_hit)
   );

   assign seq_pos = seq_frame && ((dbl_pend_ff && ptr_seq == SEQ_REG_DOUBLE) ||
                    (just_hit && ((ptr_seq == SEQ_SINGLE_ALT && !phase_ff[0]) ||
                                  (ptr_seq == SEQ_REG_DOUBLE) ||
                                  (ptr_seq == SEQ_DOUBLE_ALT && !phase_ff[1]))));
   assign seq_neg = seq_frame && !dbl_pend_ff &&
                    just_hit && ((ptr_seq == SEQ_SINGLE_ALT && phase_ff[0]) ||
                                 (ptr_seq == SEQ_REG_MISSING && !special_ph) ||
                                 (ptr_seq == SEQ_DOUBLE_ALT && phase_ff[1]));

   wire [9:0] ptr_mv   = ptr_move(ptr_value_ff, ptr_amount, ptr_dir_neg, ptr_span);
   wire [9:0] ptr_step = ptr_move(ptr_value_ff, 10'h001, seq_neg, ptr_span);
   wire [9:0] nxt_ptr  = apply_now ? (ptr_jump ? ptr_amount : ptr_mv) :
                         (seq_pos || seq_neg) ? ptr_step : ptr_value_ff;
   wire       nxt_dbl  = seq_frame && just_hit && !dbl_pend_ff &&
                         (ptr_seq == SEQ_REG_DOUBLE) && special_ph;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         apply_pend_ff    <= 1'b0;
         dbl_pend_ff      <= 1'b0;
         phase_ff         <= 3'h0;
         ptr_tu_ff        <= 1'b0;
         ptr_value_ff     <= 10'h000;
         new_data_flag_ff <= `DATA_FLAG_OFF;
         just_pos_ff      <= 1'b0;
         just_neg_ff      <= 1'b0;
      end else begin
         apply_pend_ff <= nxt_apply;
         if (ptr_seq == SEQ_NONE) begin
            phase_ff    <= 3'h0;
            dbl_pend_ff <= 1'b0;
         end else if (seq_frame) begin
            dbl_pend_ff <= nxt_dbl;
            if (just_hit && !dbl_pend_ff) begin
               phase_ff <= phase_ff + 3'h1;
            end
         end
         if (frame_start) begin
            ptr_tu_ff        <= ptr_on_tu;
            ptr_value_ff     <= nxt_ptr;
            new_data_flag_ff <= (apply_now && ptr_flag_incl) ? `DATA_FLAG_ON
                                                             : `DATA_FLAG_OFF;
            just_pos_ff      <= seq_pos;
            just_neg_ff      <= seq_neg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overhead replace and transmit clock

   wire        replace_on = (port_mode == PORT_OH_REPLACE);
   wire        force_rec  = (port_mode == PORT_THROUGH) || replace_on;
   wire clk_src_t nxt_src = force_rec ? CLK_RECOVERED : clk_select;
   wire        nxt_present = (nxt_src == CLK_EXTERNAL)  ? ext_clk_seen :
                             (nxt_src == CLK_RECOVERED) ? rec_clk_seen : 1'b1;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         oh_replace_ff  <= 1'b0;
         oh_region_ff   <= OH_TOH;
         oh_byte_ff     <= 7'h00;
         clk_src_ff     <= CLK_INTERNAL;
         clk_present_ff <= 1'b1;
      end else begin
         clk_src_ff     <= nxt_src;
         clk_present_ff <= nxt_present;
         if (frame_start) begin
            oh_replace_ff <= replace_on;
            oh_region_ff  <= oh_region;
            oh_byte_ff    <= oh_byte_pos;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking chk_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   logic [33:0] gap_ff;
   logic        gap_seen_ff;

   always_ff @(posedge sys_clk) begin
      if (rst || insert_mode != INS_RATE) begin
         gap_ff      <= '0;
         gap_seen_ff <= 1'b0;
      end else if (frame_start) begin
         gap_ff      <= rate_hit ? '0 : gap_ff + 34'h1;
         gap_seen_ff <= gap_seen_ff || rate_hit;
      end
   end

   off_quiet_a: assert property (mode_ff == INS_OFF |-> !frame_inject_ff)
      else $error("injection while insertion is off");
   perm_every_a: assert property (mode_ff == INS_PERM |-> frame_inject_ff)
      else $error("permanent mode missed a frame");
   burst_end_a: assert property (frame_start && insert_mode == INS_MANUAL &&
      state_ff == ST_BURST && left_ff == 16'h0001 |=> state_ff == ST_IDLE && frame_inject_ff)
      else $error("manual burst did not end after its count");
   rate_gap_a: assert property (frame_start && rate_hit && gap_seen_ff &&
      $stable(rate_exp) |-> gap_ff == rate_limit - 34'h1)
      else $error("rate mode spacing wrong");
   flag_apply_a: assert property (apply_now |=> new_data_flag_ff ==
      ($past(ptr_flag_incl) ? `DATA_FLAG_ON : `DATA_FLAG_OFF))
      else $error("new data flag pattern wrong on apply");
   seq_none_a: assert property (frame_start && ptr_seq == SEQ_NONE && !apply_pend_ff
      |=> !just_pos_ff && !just_neg_ff && $stable(ptr_value_ff))
      else $error("justification with sequence none");
   jump_load_a: assert property (apply_now && ptr_jump |=>
      ptr_value_ff == $past(ptr_amount))
      else $error("jump did not load pointer");
   force_rec_a: assert property (port_mode != PORT_NORMAL && port_mode == $past(port_mode)
      |-> clk_src_ff == CLK_RECOVERED)
      else $error("through or replace mode not on recovered clock");
   freq_off_a: assert property (##1 nco_step_ff == `NCO_NOMINAL +
      {{16{$past(freq_offset[15])}}, $past(freq_offset)})
      else $error("line rate offset wrong");
   no_change_a: assert property (!frame_start |=> $stable(frame_inject_ff) &&
      $stable(ptr_value_ff))
      else $error("frame output changed mid frame");

   manual_cov_c: cover property (state_ff == ST_BURST ##1 state_ff == ST_IDLE);
   alt_cov_c:    cover property (state_ff == ST_ALT_ERR ##[1:40] state_ff == ST_ALT_CLEAN);
   rate_cov_c:   cover property (mode_ff == INS_RATE && frame_inject_ff);
   jump_cov_c:   cover property (apply_now && ptr_jump && ptr_flag_incl);

endmodule

`default_nettype wire

// file: pkg/sdh_inj_defines.svh
// constants for the sdh error and pointer stimulus block
`ifndef SDH_INJ_DEFINES_SVH
`define SDH_INJ_DEFINES_SVH

// frames per injected frame in rate mode, one decade each
`define RATE_E3         34'h0_0000_03E8
`define RATE_E4         34'h0_0000_2710
`define RATE_E5         34'h0_0001_86A0
`define RATE_E6         34'h0_000F_4240
`define RATE_E7         34'h0_0098_9680
`define RATE_E8         34'h0_05F5_E100
`define RATE_E9         34'h0_3B9A_CA00
`define RATE_E10        34'h2_540B_E400

// pointer value span: au-4 0..782, tu-12 0..139
`define PTR_SPAN_AU     11'h30F
`define PTR_SPAN_TU     11'h08C

// new data flag nibble patterns
`define DATA_FLAG_ON    4'h9
`define DATA_FLAG_OFF   4'h6

// every 8th justification of a regular stream is doubled or dropped
`define SEQ_SPECIAL_PH  3'h7

// line rate nco step at zero offset, one lsb per offset unit
`define NCO_NOMINAL     32'h4000_0000

`endif

// file: pkg/sdh_inj_pkg.sv
// types for the sdh error and pointer stimulus block
package sdh_inj_pkg;

   typedef enum logic [2:0] {
      INS_OFF    = 3'b000,
      INS_MANUAL = 3'b001,
      INS_PERM   = 3'b010,
      INS_ALT    = 3'b011,
      INS_RATE   = 3'b100
   } insert_mode_t;

   typedef enum logic [2:0] {
      SEQ_NONE        = 3'b000,
      SEQ_SINGLE_ALT  = 3'b001,
      SEQ_REG_DOUBLE  = 3'b010,
      SEQ_REG_MISSING = 3'b011,
      SEQ_DOUBLE_ALT  = 3'b100
   } ptr_seq_t;

   typedef enum logic [1:0] {
      PORT_NORMAL     = 2'b00,
      PORT_THROUGH    = 2'b01,
      PORT_OH_REPLACE = 2'b10
   } port_mode_t;

   typedef enum logic [1:0] {
      CLK_INTERNAL  = 2'b00,
      CLK_EXTERNAL  = 2'b01,
      CLK_RECOVERED = 2'b10
   } clk_src_t;

   typedef enum logic [2:0] {
      OH_TOH      = 3'b000,
      OH_A1A2     = 3'b001,
      OH_K1K2     = 3'b010,
      OH_S1       = 3'b011,
      OH_DCC_1_3  = 3'b100,
      OH_DCC_4_12 = 3'b101,
      OH_J0       = 3'b110,
      OH_ONE_BYTE = 3'b111
   } oh_region_t;

   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_BURST     = 2'b01,
      ST_ALT_ERR   = 2'b10,
      ST_ALT_CLEAN = 2'b11
   } inj_state_t;

endpackage

// file: hw/frame_interval_counter.sv
// frame counter that pulses once every limit ticks
`timescale 1ns/100ps
`default_nettype none

module frame_interval_counter #(
   parameter int W = 16
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         clr,
   input  wire logic         tick,
   input  wire logic [W-1:0] limit,
   output logic              hit
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   wire          at_last = (limit <= W'(1)) || (cnt_ff >= limit - W'(1));

   assign hit     = tick && at_last;
   assign nxt_cnt = at_last ? '0 : cnt_ff + W'(1);

   always_ff @(posedge sys_clk) begin
      if (rst || clr) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule

`default_nettype wire

// file: verif/frame_source_model.sv
// frame pacer and per-frame tally of the signal seen by the equipment under test
`timescale 1ns/100ps
`default_nettype none

module frame_source_model (
   input  wire logic        sys_clk,
   input  wire logic        clr,
   input  wire logic [15:0] target,
   input  wire logic        frame_inject_ff,
   input  wire logic        just_pos_ff,
   input  wire logic        just_neg_ff,
   output logic             frame_start,
   output var int           n_frames,
   output var int           n_inj,
   output var int           n_pos,
   output var int           n_neg
);
   logic       fs_d;
   logic       hold;
   logic [1:0] gap;

   initial begin
      frame_start = 1'b0;
      fs_d = 1'b0;
      gap = 2'h0;
      n_frames = 0;
      n_inj = 0;
      n_pos = 0;
      n_neg = 0;
   end

   // tally reads what the previous frame edge left standing
   always @(posedge sys_clk) begin
      if (fs_d) begin
         n_inj = n_inj + int'(frame_inject_ff);
         n_pos = n_pos + int'(just_pos_ff);
         n_neg = n_neg + int'(just_neg_ff);
      end
      fs_d = frame_start;
      hold = clr;
      if (hold) begin
         n_frames = 0;
         n_inj = 0;
         n_pos = 0;
         n_neg = 0;
      end
      #1;
      gap = gap + 2'h1;
      frame_start = (gap == 2'h0) && !hold && (n_frames < int'(target));
      if (frame_start) n_frames = n_frames + 1;
   end
endmodule

`default_nettype wire

// file: verif/tb_sdh_error_pointer_injector.sv
// self-checking bench for the sdh error and pointer stimulus block
`timescale 1ns/100ps
`default_nettype none
`include "sdh_inj_defines.svh"

module tb_sdh_error_pointer_injector import sdh_inj_pkg::*;;
   logic sys_clk = 1'b0, rst = 1'b1, clr = 1'b0, frame_start;
   logic [15:0] target = 16'h0;
   int n_frames, n_inj, n_pos, n_neg, bad_count = 0, n_compared = 0;
   insert_mode_t insert_mode;
   ptr_seq_t ptr_seq;
   port_mode_t port_mode;
   oh_region_t oh_region, oh_region_ff;
   clk_src_t clk_select, clk_src_ff;
   logic inject_alarm, insert_trigger, ptr_on_tu, ptr_jump, ptr_dir_neg, ptr_flag_incl;
   logic ptr_apply, ext_clk_seen, rec_clk_seen;
   logic [15:0] burst_count, alt_err_frames, alt_clean_frames, just_period;
   logic [3:0] rate_exp, new_data_flag_ff;
   logic signed [15:0] freq_offset;
   logic [9:0] ptr_amount, ptr_value_ff;
   logic [6:0] oh_byte_pos, oh_byte_ff;
   logic frame_inject_ff, inject_alarm_ff, burst_busy_ff, insert_active_ff, ptr_tu_ff;
   logic just_pos_ff, just_neg_ff, oh_replace_ff, clk_present_ff;
   logic [31:0] nco_step_ff;

   always #5 sys_clk = ~sys_clk;

   sdh_error_pointer_injector DUT (.sys_clk, .rst, .frame_start, .insert_mode, .inject_alarm,
      .insert_trigger, .burst_count, .alt_err_frames, .alt_clean_frames, .rate_exp,
      .freq_offset, .ptr_on_tu, .ptr_seq, .just_period, .ptr_jump, .ptr_dir_neg,
      .ptr_flag_incl, .ptr_amount, .ptr_apply, .port_mode, .oh_region, .oh_byte_pos,
      .clk_select, .ext_clk_seen, .rec_clk_seen, .frame_inject_ff, .inject_alarm_ff,
      .burst_busy_ff, .insert_active_ff, .nco_step_ff, .ptr_tu_ff, .ptr_value_ff,
      .new_data_flag_ff, .just_pos_ff, .just_neg_ff, .oh_replace_ff, .oh_region_ff,
      .oh_byte_ff, .clk_src_ff, .clk_present_ff);

   frame_source_model far_end (.sys_clk, .clr, .target, .frame_inject_ff, .just_pos_ff,
      .just_neg_ff, .frame_start, .n_frames, .n_inj, .n_pos, .n_neg);

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic tick();
      @(posedge sys_clk) #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // target is raised only after the clear edge so no stray frame slips in
   task automatic run_frames(input int n);
      clr = 1'b1;
      tick();
      clr = 1'b0;
      target = n[15:0];
      for (int k = 0; k < 8 * n + 20 && n_frames < n; k++) tick();
      repeat (3) tick();
      chk(n_frames, n);
   endtask

   task automatic pulse_trigger();
      insert_trigger = 1'b1;
      tick();
      insert_trigger = 1'b0;
   endtask

   task automatic apply(input logic jmp, input logic neg, input logic flg,
                        input logic [9:0] amt);
      ptr_jump = jmp;
      ptr_dir_neg = neg;
      ptr_flag_incl = flg;
      ptr_amount = amt;
      ptr_apply = 1'b1;
      tick();
      ptr_apply = 1'b0;
      run_frames(1);
   endtask

   task automatic seq_case(input ptr_seq_t s, input logic [15:0] per, input int n);
      ptr_seq = s;
      just_period = per;
      run_frames(n);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic t_insert();
      pulse_trigger();
      run_frames(5);
      chk(n_inj, 0);
      chk(burst_busy_ff, 1'b0);
      insert_mode = INS_MANUAL;
      run_frames(2);
      pulse_trigger();
      chk(burst_busy_ff, 1'b1);
      run_frames(5);
      chk(n_inj, 2);
      chk(burst_busy_ff, 1'b0);
      insert_mode = INS_PERM;
      inject_alarm = 1'b1;
      repeat (3) tick();
      chk(frame_inject_ff, 1'b0);
      pulse_trigger();
      run_frames(6);
      chk(n_inj, 6);
      chk(inject_alarm_ff, 1'b1);
      chk(burst_busy_ff, 1'b0);
      chk(insert_active_ff, 1'b1);
      insert_mode = INS_ALT;
      run_frames(10);
      chk(n_inj, 4);
      insert_mode = INS_OFF;
      run_frames(3);
      chk(n_inj, 0);
      chk(insert_active_ff, 1'b0);
      insert_mode = INS_RATE;
      run_frames(2000);
      chk(n_inj, 2);
      rate_exp = 4'h4;
      run_frames(2000);
      chk(n_inj, 0);
      insert_mode = INS_OFF;
      run_frames(1);
      $display("insertion modes done");
   endtask

   task automatic t_freq();
      freq_offset = -16'sd50;
      repeat (2) tick();
      chk(nco_step_ff, `NCO_NOMINAL - 32'h32);
      freq_offset = 16'sd100;
      repeat (2) tick();
      chk(nco_step_ff, `NCO_NOMINAL + 32'h64);
      $display("frequency offset done");
   endtask

   task automatic t_pointer();
      apply(1'b1, 1'b0, 1'b1, 10'h064);
      chk(ptr_value_ff, 10'h064);
      chk(new_data_flag_ff, `DATA_FLAG_ON);
      ptr_amount = 10'h005;
      run_frames(2);
      chk(new_data_flag_ff, `DATA_FLAG_OFF);
      chk(ptr_value_ff, 10'h064);
      apply(1'b0, 1'b0, 1'b0, 10'h005);
      chk(ptr_value_ff, 10'h069);
      apply(1'b0, 1'b1, 1'b0, 10'h00A);
      chk(ptr_value_ff, 10'h05F);
      apply(1'b1, 1'b0, 1'b0, 10'h30E);
      apply(1'b0, 1'b0, 1'b0, 10'h001);
      chk(ptr_value_ff, 10'h000);
      ptr_on_tu = 1'b1;
      apply(1'b1, 1'b0, 1'b0, 10'h000);
      apply(1'b0, 1'b1, 1'b0, 10'h001);
      chk(ptr_value_ff, 10'h08B);
      chk(ptr_tu_ff, 1'b1);
      seq_case(SEQ_NONE, 16'h1, 8);
      chk(n_pos + n_neg, 0);
      chk(ptr_value_ff, 10'h08B);
      seq_case(SEQ_SINGLE_ALT, 16'h1, 8);
      chk({n_pos[15:0], n_neg[15:0]}, {16'h4, 16'h4});
      seq_case(SEQ_DOUBLE_ALT, 16'h1, 8);
      chk({n_pos[15:0], n_neg[15:0]}, {16'h4, 16'h4});
      seq_case(SEQ_REG_MISSING, 16'h2, 16);
      chk({n_pos[15:0], n_neg[15:0]}, {16'h0, 16'h7});
      seq_case(SEQ_REG_DOUBLE, 16'h2, 17);
      chk({n_pos[15:0], n_neg[15:0]}, {16'h9, 16'h0});
      ptr_seq = SEQ_NONE;
      $display("pointer actions done");
   endtask

   task automatic t_overhead_clock();
      port_mode = PORT_OH_REPLACE;
      for (int r = 0; r < 8; r++) begin
         oh_region = oh_region_t'(r[2:0]);
         run_frames(1);
         chk({oh_replace_ff, oh_region_ff, oh_byte_ff}, {1'b1, r[2:0], 7'h2A});
         chk(clk_src_ff, CLK_RECOVERED);
      end
      port_mode = PORT_THROUGH;
      run_frames(1);
      chk({oh_replace_ff, clk_src_ff}, {1'b0, CLK_RECOVERED});
      port_mode = PORT_NORMAL;
      run_frames(1);
      chk({clk_src_ff, clk_present_ff}, {CLK_EXTERNAL, 1'b0});
      ext_clk_seen = 1'b1;
      repeat (2) tick();
      chk(clk_present_ff, 1'b1);
      clk_select = CLK_RECOVERED;
      repeat (2) tick();
      chk({clk_src_ff, clk_present_ff}, {CLK_RECOVERED, 1'b0});
      rec_clk_seen = 1'b1;
      repeat (2) tick();
      chk(clk_present_ff, 1'b1);
      clk_select = CLK_INTERNAL;
      repeat (2) tick();
      chk({clk_src_ff, clk_present_ff}, {CLK_INTERNAL, 1'b1});
      $display("overhead and clock done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {insert_mode, ptr_seq, port_mode, oh_region} = '0;
      {inject_alarm, insert_trigger, ptr_on_tu, ptr_jump, ptr_dir_neg} = '0;
      {ptr_flag_incl, ptr_apply, ext_clk_seen, rec_clk_seen} = '0;
      clk_select = CLK_EXTERNAL;
      {burst_count, alt_err_frames, alt_clean_frames} = {16'h2, 16'h2, 16'h3};
      {just_period, rate_exp, freq_offset} = {16'h1, 4'h3, 16'sd0};
      {ptr_amount, oh_byte_pos} = {10'h0, 7'h2A};
      repeat (6) @(posedge sys_clk);
      #1 rst = 1'b0;
      chk({nco_step_ff, new_data_flag_ff}, {`NCO_NOMINAL, `DATA_FLAG_OFF});
      clk_select = CLK_INTERNAL;
      t_insert();
      t_freq();
      t_pointer();
      clk_select = CLK_EXTERNAL;
      t_overhead_clock();
      give_verdict();
   end

   // whole run is near 17k cycles; 40k leaves margin without masking a hang
   initial begin
      #400us;
      bad_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      give_verdict();
   end
endmodule

`default_nettype wire
